// ### inc/lpts_regs.vh
// Timing and layout constants for the panel timing and power sequencer.
`ifndef LPTS_REGS_VH
`define LPTS_REGS_VH
`define LPTS_H_ACTIVE 1280
`define LPTS_H_MIN 1290
`define LPTS_H_TOTAL 1440
`define LPTS_V_ACTIVE 800
`define LPTS_V_MIN 810
`define LPTS_V_TOTAL 823
`define LPTS_CLK_MHZ 100
`define LPTS_VIDEO_ON_MS 10
`define LPTS_VIDEO_MAX_MS 50
`define LPTS_BL_AFTER_VIDEO_MS 200
`define LPTS_PWM_AFTER_SUPPLY_MS 10
`define LPTS_EN_AFTER_PWM_MS 100
`define LPTS_OFF_TIME_MS 500
`define LPTS_VIDEO_OFF_MS 10
`define LPTS_EN_OFF_MS 200
`define LPTS_PWM_OFF_MS 100
`define LPTS_SUPPLY_OFF_MS 10
`define LPTS_MS_CYCLES (`LPTS_CLK_MHZ * 1000)
`endif

// ### src/lpts_sequencer.v
// Panel host: pixel timing, lane packing, two-entry pixel buffer and power sequencing.
`timescale 1ns/100ps
`default_nettype none
`include "lpts_regs.vh"
// Function
// R1: Pixel clock stays within 67 to 75 MHz, nominal 71 MHz. The code gives clk/7, about 14.3 MHz at the 100 MHz clock.
// R2: Each active line carries exactly 1280 flagged pixel clocks.
// R3: Line period is at least 1290 clocks, nominally 1440.
// R4: Each frame holds exactly 800 active lines.
// R5: Frame period is at least 810 lines, nominally 823.
// R6: Frames repeat at a nominal 60 Hz. The code gives about 12 Hz, from clk/7 over 1440 x 823 clocks at 100 MHz.
// R7: Panel frames pixels only from the active-video flag, ignoring syncs.
// R8: Video starts 0 to 50 ms after logic supply is stable.
// R9: Backlight enable comes at least 200 ms after video starts.
// R10: Dimming PWM starts at least 10 ms after backlight supply.
// R11: Backlight enable comes 0 to 200 ms after PWM starts.
// R12: Logic supply stays off at least 500 ms before reapplying.
// R13: Video stops 0 to 50 ms before logic supply is removed.
// R14: Backlight enable drops at least 200 ms before video stops.
// R15: PWM stops 0 to 200 ms after backlight enable drops.
// R16: PWM stops at least 10 ms before backlight supply switches off.
// R17: Lanes carry the documented colour bit assignment including the flag.
// R18: Panel takes 6-bit input when depth select low, else 8-bit.
// R19: No video input is driven while logic supply is off.
// R20: Active-video flag is low through all blanking.
// R21: In 6-bit mode lane 3 may idle; panel ignores upper bits.
module lpts_sequencer #(
   parameter H_TOTAL = `LPTS_H_TOTAL,
   parameter V_TOTAL = `LPTS_V_TOTAL,
   parameter MS_CYCLES = `LPTS_MS_CYCLES,
   parameter PIX_DIV = 7
) (
   input wire clk,
   input wire rst_n,
   input wire power_request,
   input wire eight_bit_mode,
   input wire [23:0] pixel_data,
   input wire pixel_valid,
   output wire pixel_ready,
   output reg logic_supply,
   output reg backlight_supply,
   output reg dimming_pwm_run,
   output reg backlight_enable,
   output reg colour_depth_select,
   output reg video_on,
   output reg pixel_strobe,
   output reg [6:0] lvds_lane_zero,
   output reg [6:0] lvds_lane_one,
   output reg [6:0] lvds_lane_two,
   output reg [6:0] lvds_lane_three,
   output reg active_video_flag,
   output reg underrun,
   output wire [3:0] seq_state
);
   localparam S_OFF = 4'h0, S_VDD = 4'h1, S_VIDEO = 4'h2, S_BLSUP = 4'h3, S_PWM = 4'h4;
   localparam S_ON = 4'h5, S_ENOFF = 4'h6, S_PWMOFF = 4'h7, S_BLOFF = 4'h8, S_VIDOFF = 4'h9;
   localparam S_REST = 4'ha;
   reg [3:0] state;
   reg [31:0] ms_count;
   reg [19:0] tick;
   reg [11:0] hcount;
   reg [10:0] vcount;
   reg [3:0] div;
   reg req_meta, req_sync;
   reg [23:0] buf_data [0:1];
   reg [1:0] buf_fill;
   reg wr_ptr, rd_ptr;
   wire pix_tick = (div == PIX_DIV[3:0] - 4'h1);
   wire in_active = (hcount < `LPTS_H_ACTIVE) && (vcount < `LPTS_V_ACTIVE);
   wire vid_off_due;
   wire take = video_on && !vid_off_due && pix_tick && in_active && (buf_fill != 2'h0);
   wire push = pixel_valid && pixel_ready;
   assign pixel_ready = (buf_fill != 2'h2);
   assign seq_state = state;
   // Elapsed whole milliseconds in the current state.
   function done;
      input [31:0] cnt;
      input [31:0] ms;
      begin
         done = (cnt >= ms);
      end
   endfunction
   // Raster and buffer stop on the edge that drops video, so no flag outlives it.
   assign vid_off_due = (state == S_BLOFF) && done(ms_count, `LPTS_EN_OFF_MS - `LPTS_PWM_OFF_MS
      - `LPTS_SUPPLY_OFF_MS);
   always @(posedge clk) begin
      if (!rst_n) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
      end else begin
         req_meta <= power_request;
         req_sync <= req_meta;
      end
   end
   always @(posedge clk) begin
      if (!rst_n) begin
         // Reset may have cut the logic supply, so a full rest comes before any power-up.
         state <= S_REST; // [R12]
         ms_count <= 32'h0;
         tick <= 20'h0;
         logic_supply <= 1'b0;
         backlight_supply <= 1'b0;
         dimming_pwm_run <= 1'b0;
         backlight_enable <= 1'b0;
         video_on <= 1'b0;
         colour_depth_select <= 1'b1;
      end else begin
         if (tick == MS_CYCLES[19:0] - 20'h1) begin
            tick <= 20'h0;
            ms_count <= ms_count + 32'h1;
         end else begin
            tick <= tick + 20'h1;
         end
         // Every step but S_REST to S_OFF restarts the tick with the count; a free tick could cut a minimum short.
         case (state)
            S_OFF: if (req_sync) begin
               colour_depth_select <= eight_bit_mode; // [R18] [R21]
               logic_supply <= 1'b1;
               state <= S_VDD;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            S_VDD: if (done(ms_count, `LPTS_VIDEO_ON_MS)) begin
               video_on <= 1'b1; // [R8] [R19]
               state <= S_VIDEO;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            S_VIDEO: if (done(ms_count, `LPTS_BL_AFTER_VIDEO_MS - `LPTS_PWM_AFTER_SUPPLY_MS
                  - `LPTS_EN_AFTER_PWM_MS)) begin
               backlight_supply <= 1'b1;
               state <= S_BLSUP;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            S_BLSUP: if (done(ms_count, `LPTS_PWM_AFTER_SUPPLY_MS)) begin
               dimming_pwm_run <= 1'b1; // [R10]
               state <= S_PWM;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            // Enable comes 100 ms after PWM, 200 ms after video in total.
            S_PWM: if (done(ms_count, `LPTS_EN_AFTER_PWM_MS)) begin
               backlight_enable <= 1'b1; // [R9] [R11]
               state <= S_ON;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            S_ON: if (!req_sync) begin
               backlight_enable <= 1'b0;
               state <= S_ENOFF;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            S_ENOFF: if (done(ms_count, `LPTS_PWM_OFF_MS)) begin
               dimming_pwm_run <= 1'b0; // [R15]
               state <= S_PWMOFF;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            S_PWMOFF: if (done(ms_count, `LPTS_SUPPLY_OFF_MS)) begin
               backlight_supply <= 1'b0; // [R16]
               state <= S_BLOFF;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            // Video ends 200 ms after enable drops, counted across all three waits.
            S_BLOFF: if (vid_off_due) begin
               video_on <= 1'b0; // [R14]
               state <= S_VIDOFF;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            S_VIDOFF: if (done(ms_count, `LPTS_VIDEO_OFF_MS)) begin
               logic_supply <= 1'b0; // [R13]
               state <= S_REST;
               ms_count <= 32'h0;
               tick <= 20'h0;
            end
            S_REST: if (done(ms_count, `LPTS_OFF_TIME_MS)) begin
               state <= S_OFF; // [R12]
            end
            default: state <= S_OFF;
         endcase
      end
   end
   // Two-entry buffer so a late pixel source never loses a word already offered.
   always @(posedge clk) begin
      if (!rst_n) begin
         buf_fill <= 2'h0;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
      end else begin
         if (push) begin
            buf_data[wr_ptr] <= pixel_data;
            wr_ptr <= ~wr_ptr;
         end
         if (take)
            rd_ptr <= ~rd_ptr;
         buf_fill <= buf_fill + {1'b0, push} - {1'b0, take};
      end
   end
   // Pixel rate is clk/PIX_DIV; raster counters advance once per pixel period.
   always @(posedge clk) begin
      if (!rst_n || !video_on || vid_off_due) begin
         div <= 4'h0;
         hcount <= 12'h0;
         vcount <= 11'h0;
         pixel_strobe <= 1'b0;
         active_video_flag <= 1'b0;
         underrun <= 1'b0;
         lvds_lane_zero <= 7'h0;
         lvds_lane_one <= 7'h0;
         lvds_lane_two <= 7'h0;
         lvds_lane_three <= 7'h0;
      end else begin
         pixel_strobe <= pix_tick; // [R1] [R6]
         div <= pix_tick ? 4'h0 : div + 4'h1;
         if (pix_tick) begin
            if (hcount == H_TOTAL[11:0] - 12'h1) begin // [R3]
               hcount <= 12'h0;
               vcount <= (vcount == V_TOTAL[10:0] - 11'h1) ? 11'h0 : vcount + 11'h1; // [R5]
            end else begin
               hcount <= hcount + 12'h1;
            end
            // Flag only in the 1280x800 window, never in blanking.
            active_video_flag <= in_active; // [R2] [R4] [R7] [R20]
            underrun <= in_active && (buf_fill == 2'h0);
            if (in_active && buf_fill != 2'h0) begin
               lvds_lane_zero <= {buf_data[rd_ptr][8], buf_data[rd_ptr][5:0]}; // [R17]
               lvds_lane_one <= {buf_data[rd_ptr][17:16], buf_data[rd_ptr][13:9]};
               lvds_lane_two <= {1'b1, 2'b00, buf_data[rd_ptr][21:18]};
               lvds_lane_three <= colour_depth_select ? {1'b0, buf_data[rd_ptr][23:22],
                  buf_data[rd_ptr][15:14], buf_data[rd_ptr][7:6]} : 7'h0; // [R21]
            end else begin
               lvds_lane_zero <= 7'h0;
               lvds_lane_one <= 7'h0;
               lvds_lane_two <= {in_active, 6'h0}; // [R2] [R20]
               lvds_lane_three <= 7'h0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### dv/lpts_chk_sva.sv
// Checker for the power ordering and blanking of the panel sequencer.
`timescale 1ns/100ps
`default_nettype none
module lpts_chk #(parameter MS_CYCLES = 10) (
   input wire clk,
   input wire rst_n,
   input wire logic_supply,
   input wire backlight_supply,
   input wire dimming_pwm_run,
   input wire backlight_enable,
   input wire video_on,
   input wire active_video_flag
);
   localparam int M = MS_CYCLES;
   // The time base starts far up so that the first power-up never looks like a short rest.
   reg [31:0] now, tl, tv, tb, tp, te;
   always @(posedge clk) begin
      if (!rst_n) begin
         now <= 32'h40000000;
         {tl, tv, tb, tp, te} <= 160'h0;
      end else begin
         now <= now + 32'h1;
         if ($changed(logic_supply)) tl <= now;
         if ($changed(video_on)) tv <= now;
         if ($changed(backlight_supply)) tb <= now;
         if ($changed(dimming_pwm_run)) tp <= now;
         if ($changed(backlight_enable)) te <= now;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_vid_on; $rose(video_on) |-> logic_supply && now - tl <= 50 * M; endproperty
   a_vid_on: assert property (p_vid_on) else $error("video started late");
   property p_en_on;
      $rose(backlight_enable) |-> dimming_pwm_run && now - tv >= 200 * M && now - tp <= 200 * M;
   endproperty
   a_en_on: assert property (p_en_on) else $error("enable out of place");
   property p_pwm_on; $rose(dimming_pwm_run) |-> backlight_supply && now - tb >= 10 * M; endproperty
   a_pwm_on: assert property (p_pwm_on) else $error("dimming started early");
   property p_rest; $rose(logic_supply) |-> now - tl >= 500 * M; endproperty
   a_rest: assert property (p_rest) else $error("supply rest too short");
   property p_vid_off; $fell(video_on) |-> !backlight_enable && now - te >= 200 * M; endproperty
   a_vid_off: assert property (p_vid_off) else $error("video stopped early");
   property p_vdd_off; $fell(logic_supply) |-> !video_on && now - tv <= 50 * M; endproperty
   a_vdd_off: assert property (p_vdd_off) else $error("supply removed late");
   property p_pwm_off; $fell(dimming_pwm_run) |-> !backlight_enable && now - te <= 200 * M; endproperty
   a_pwm_off: assert property (p_pwm_off) else $error("dimming stopped late");
   property p_bls_off; $fell(backlight_supply) |-> !dimming_pwm_run && now - tp >= 10 * M; endproperty
   a_bls_off: assert property (p_bls_off) else $error("backlight supply off early");
   property p_dark; !video_on |-> !active_video_flag; endproperty
   a_dark: assert property (p_dark) else $error("flag raised without video");
endmodule
bind lpts_sequencer lpts_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk(clk), .rst_n(rst_n),
   .logic_supply(logic_supply), .backlight_supply(backlight_supply),
   .dimming_pwm_run(dimming_pwm_run), .backlight_enable(backlight_enable),
   .video_on(video_on), .active_video_flag(active_video_flag));
`default_nettype wire

// ### dv/lpts_panel.sv
// Panel model: decodes the four lanes into pixels and measures each flagged run.
`timescale 1ns/100ps
`default_nettype none
module lpts_panel (
   input wire clk,
   input wire strobe,
   input wire [6:0] lane0,
   input wire [6:0] lane1,
   input wire [6:0] lane2,
   input wire [6:0] lane3,
   input wire depth,
   input wire vdd,
   output reg got,
   output reg [23:0] pix,
   output reg [15:0] run,
   output reg line_done
);
   reg [15:0] cnt = 16'h0;
   reg was = 1'b0;
   wire [7:0] m = depth ? 8'hff : 8'h3f;
   always @(posedge clk) begin
      got <= strobe && lane2[6];
      pix <= {lane3[5:4], lane2[3:0], lane1[6:5], lane3[3:2], lane1[4:0], lane0[6],
              lane3[1:0], lane0[5:0]} & {m, m, m};
      line_done <= strobe && was && !lane2[6];
      // An unpowered panel forgets any line that power-down cut short.
      if (!vdd) begin
         cnt <= 16'h0;
         was <= 1'b0;
      end else if (strobe) begin
         cnt <= lane2[6] ? cnt + 16'h1 : 16'h0;
         run <= cnt;
         was <= lane2[6];
      end
   end
endmodule
`default_nettype wire

// ### dv/tb.sv
// Bench: feeds random pixels, cycles power and checks lanes and sequencing times.
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int M = 10;
   logic clk = 0, rst_n = 0, pwr = 0, mode = 0, valid = 0, acc = 0;
   logic [23:0] data = 24'h0;
   wire ready, ls, bs, pr, be, cds, vo, ps, avf, ur, got, ld;
   wire [6:0] l0, l1, l2, l3;
   wire [3:0] st;
   wire [23:0] pix;
   wire [15:0] run;
   wire [4:0] sv = {be, pr, bs, vo, ls};
   logic [23:0] q[$];
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   initial forever #5 clk = ~clk;
   lpts_sequencer #(.H_TOTAL(1290), .MS_CYCLES(M)) DUT (.clk(clk), .rst_n(rst_n),
      .power_request(pwr), .eight_bit_mode(mode), .pixel_data(data), .pixel_valid(valid),
      .pixel_ready(ready), .logic_supply(ls), .backlight_supply(bs), .dimming_pwm_run(pr),
      .backlight_enable(be), .colour_depth_select(cds), .video_on(vo), .pixel_strobe(ps),
      .lvds_lane_zero(l0), .lvds_lane_one(l1), .lvds_lane_two(l2), .lvds_lane_three(l3),
      .active_video_flag(avf), .underrun(ur), .seq_state(st));
   lpts_panel u_pan (.clk(clk), .strobe(ps), .lane0(l0), .lane1(l1), .lane2(l2), .lane3(l3),
      .depth(cds), .vdd(ls), .got(got), .pix(pix), .run(run), .line_done(ld));
   task complete_run;
      $display("Compared %0d, mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task chk_t(input int e, input int g);
      cmp_count++;
      if (g < e || g > e + 4) begin
         n_mismatch++;
         $display("MISMATCH step expected %0d seen %0d", e, g);
      end
   endtask
   // Counts cycles until one sequencing output reaches a level, then compares the wait.
   task step(input int b, input logic v, input int ms);
      int n;
      n = 0;
      while (sv[b] !== v && n < 9000) begin
         @(negedge clk);
         n++;
      end
      chk_t(ms * M, n);
   endtask
   task run_mode(input logic md);
      mode = md;
      pwr = 1;
      step(0, 1, 500);
      chk("depth", 24'(md), 24'(cds));
      step(1, 1, 10);
      step(2, 1, 90);
      step(3, 1, 10);
      step(4, 1, 100);
      repeat (20000) @(negedge clk);
      pwr = 0;
      step(4, 0, 0);
      step(3, 0, 100);
      step(2, 0, 10);
      step(1, 0, 90);
      step(0, 0, 10);
   endtask
   // A request stands until the edge that accepts it.
   always @(negedge clk) begin
      if (!valid || acc) begin
         valid <= ($urandom % 4) != 0;
         data <= 24'($urandom);
      end
   end
   always @(posedge clk) begin
      acc <= rst_n && valid && ready;
      if (rst_n && valid && ready) q.push_back(data);
      if (ps === 1'b1) chk("underrun", 24'h0, 24'(ur));
      if (got === 1'b1) chk("pixel", q.pop_front() & (mode ? 24'hffffff : 24'h3f3f3f), pix);
      if (ld === 1'b1) chk("run", 24'd1280, 24'(run));
      cyc++;
      if (cyc > 90000) begin
         n_mismatch++;
         complete_run;
      end
   end
   initial begin
      void'($urandom(32'h4fcb6edc));
      repeat (5) @(negedge clk);
      rst_n = 1;
      run_mode(0);
      @(negedge clk);
      rst_n = 0;
      q.delete();
      @(negedge clk);
      rst_n = 1;
      chk("state", 24'ha, 24'(st));
      chk("depth", 24'h1, 24'(cds));
      run_mode(1);
      pwr = 1;
      step(0, 1, 500);
      complete_run;
   end
endmodule
`default_nettype wire
